/* File: hw/vidc_core.sv */
/*
 Serial command interpreter, register set and set-point ramp of a regulator controller.
 Assumes a frame pin, link clock pin and data pin from the bus master (asynchronous),
 telemetry from logic on ref_clk_in, and a local register port on ref_clk_in.
*/
// Added by the designer: the register addresses and the strobed register port.
// How it works
// (R1) Fast set-target ramps the set point at 20 mV per microsecond.
// (R2) Slow set-target ramps the set point at 5 mV per microsecond.
// (R3) Set-power-state changes the state; its register reports the state in effect.
// (R4) Pointer-declare stores the register address in a scratch pointer.
// (R5) Data-write stores its payload in the register the pointer names.
// (R6) Register-read returns the register named in the command.
// (R7) Master never sends factory trim; device ignores it.
// (R8) Decay set-target unsupported; device ignores it.
// (R9) Margin offset pushing target above 1.52 V or below 0 V is not acknowledged.
// (R10) Code 0x00 means zero volts, output off.
// (R11) Code 0x01 is 0.250 V, plus 5 mV per code.
// (R12) A second status register records bus errors.
// (R13) A copy register keeps the earlier bus-error status.
// (R14) Target register holds the code in effect after each accepted set-target.
// (R15) Writable boot register is loaded into the target by a port write setting bit 0 of the control register; reset restores the default.
// (R16) Temperature zone and both rail currents are readable.
// (R17) Fast and slow ramp rates are held in separate registers.
// (R18) Maker, product, revision, protocol and capability registers are readable.
// (R19) Current, temperature and voltage limit registers are programmable.
// (R20) Margin offset shifts the effective target; multi-regulator config is kept.
// (R21) Device answers its strapped address (0..13) and two broadcast addresses.
// (R22) No parity on pointer-declare and data-write; both are acknowledged, save a data-write refused under R9.
// (R23) Unsupported command codes change nothing but bit 0 of the bus-error status.
`timescale 1ns/1ps
`include "vidc_defines.svh"

module vidc_core
    import vidc_pkg::*;
#(
    parameter logic [7:0] MAKER_ID = 8'h5A, // Arbitrary value
    parameter logic [7:0] PRODUCT_ID = 8'h3C, // Arbitrary value
    parameter logic [7:0] REVISION_ID = 8'h01 // Arbitrary value
) (
    input wire logic ref_clk_in, // 20 MHz clock
    input wire logic reset_in, // Synchronous reset, high
    input wire logic [3:0] addr_strap_in, // Bus address strap
    input wire logic link_clk_in, // Link clock pin
    input wire logic link_frame_in, // Frame active pin
    input wire logic link_data_in, // Serial data pin
    input wire logic [7:0] temp_zone_in, // Temperature zone, first rail
    input wire logic [7:0] current_first_in, // First rail current
    input wire logic [7:0] current_second_in, // Second rail current
    input wire logic [7:0] reg_addr_in, // Register port address
    input wire logic [7:0] reg_wdata_in, // Register port write data
    input wire logic reg_wr_in, // Register port write strobe
    input wire logic reg_rd_in, // Register port read strobe
    output logic [7:0] reg_rdata_out, // Register port read data
    output logic reply_strobe_out, // Command answered, one cycle
    output logic reply_ack_out, // Command acknowledged
    output logic [7:0] reply_data_out, // Read data for the master
    output logic [7:0] setpoint_code_out, // Ramping set-point code
    output logic [10:0] setpoint_mv_out, // Set point in millivolts
    output logic [1:0] power_state_out // Power state in effect
);
    logic [2:0] lclk_q, lfrm_q;
    logic [1:0] ldat_q;
    logic [14:0] shift_q;
    logic [3:0] bits_q, my_addr_q;
    logic cmd_v_q;
    logic [7:0] ptr_q, target_q, vboot_q, icc_q, tmax_q, vmax_q, multi_q;
    logic [7:0] margin_q, stat2_q, stat2p_q;
    logic [1:0] ps_q;
    logic slow_q;
    logic [4:0] tick_q;
    vidc_ramp_t ramp_q, ramp_d;
    logic [7:0] sp_q;

    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            lclk_q <= 3'h0;
            lfrm_q <= 3'h0;
            ldat_q <= 2'h0;
        end else begin
            lclk_q <= {lclk_q[1:0], link_clk_in};
            lfrm_q <= {lfrm_q[1:0], link_frame_in};
            ldat_q <= {ldat_q[0], link_data_in};
        end
    end

    wire lclk_rise_w = lclk_q[1] & ~lclk_q[2];
    wire frm_w = lfrm_q[1];
    wire frm_end_w = ~lfrm_q[1] & lfrm_q[2];
    wire bit_w = frm_w & lclk_rise_w & (bits_q != `VIDC_FRAME_BITS);
    wire short_w = frm_end_w & (bits_q != `VIDC_FRAME_BITS);

    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            shift_q <= 15'h0000;
            bits_q <= 4'h0;
            cmd_v_q <= 1'b0;
        end else begin
            cmd_v_q <= bit_w & (bits_q == 4'hE);
            if (bit_w) begin
                shift_q <= {shift_q[13:0], ldat_q[1]};
            end
            if (!frm_w) begin
                bits_q <= 4'h0;
            end else if (bit_w) begin
                bits_q <= bits_q + 4'h1;
            end
        end
    end

    // Strap taken while reset is held
    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            my_addr_q <= addr_strap_in;
        end
    end

    wire [3:0] f_addr_w = shift_q[14:11];
    wire [2:0] f_cmd_w = shift_q[10:8];
    wire [7:0] f_pay_w = shift_q[7:0];
    wire own_w = (my_addr_q < 4'hE) & (f_addr_w == my_addr_q);
    wire hit_w = own_w | (f_addr_w == `VIDC_BCAST_A) | (f_addr_w == `VIDC_BCAST_B); // [R21]
    wire go_w = cmd_v_q & hit_w;
    wire c_fast_w = go_w & (f_cmd_w == VIDC_CMD_FAST);
    wire c_slow_w = go_w & (f_cmd_w == VIDC_CMD_SLOW);
    wire c_ps_w = go_w & (f_cmd_w == VIDC_CMD_PS);
    wire c_ptr_w = go_w & (f_cmd_w == VIDC_CMD_PTR);
    wire c_wr_w = go_w & (f_cmd_w == VIDC_CMD_WRITE);
    wire c_rd_w = go_w & (f_cmd_w == VIDC_CMD_READ);
    // Trim and decay codes only set bit 0 of the bus-error status
    wire c_bad_w = go_w & ((f_cmd_w == VIDC_CMD_TRIM) | (f_cmd_w == VIDC_CMD_DECAY)); // [R7] [R8] [R23]
    wire c_tgt_w = c_fast_w | c_slow_w;

    wire sw_wr_w = reg_wr_in & ~c_wr_w;
    wire [7:0] wa_w = c_wr_w ? ptr_q : reg_addr_in; // [R5]
    wire [7:0] wd_w = c_wr_w ? f_pay_w : reg_wdata_in;
    wire we_w = c_wr_w | sw_wr_w;
    wire [8:0] sum_w = {1'b0, target_q} + {{1{margin_q[7]}}, margin_q};
    wire [8:0] tst_w = {1'b0, target_q} + {{1{wd_w[7]}}, wd_w};
    // Carry out marks overflow for a positive and underflow for a negative offset
    wire tst_bad_w = tst_w[8];
    wire mg_bad_w = (wa_w == `VIDC_R_MARGIN) & tst_bad_w; // [R9]
    wire wr_ok_w = we_w & ~mg_bad_w;
    wire wr_ptr_w = wr_ok_w & (wa_w == `VIDC_R_PTR);
    wire ctrl_boot_w = sw_wr_w & (reg_addr_in == `VIDC_R_CTRL) & reg_wdata_in[0];
    wire rd_st2_w = c_rd_w & (f_pay_w == `VIDC_R_STAT2);

    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            ptr_q <= 8'h00;
            vboot_q <= `VIDC_VBOOT_RST;
            icc_q <= 8'h00;
            tmax_q <= 8'h00;
            vmax_q <= 8'hFF;
            margin_q <= 8'h00;
            multi_q <= 8'h00;
        end else begin
            if (c_ptr_w) begin
                ptr_q <= f_pay_w; // [R4] [R22]
            end else if (wr_ptr_w) begin
                ptr_q <= wd_w;
            end
            if (wr_ok_w) begin
                case (wa_w) // [R5] [R19] [R20]
                    `VIDC_R_VBOOT: vboot_q <= wd_w; // [R15]
                    `VIDC_R_ICCMAX: icc_q <= wd_w;
                    `VIDC_R_TMAX: tmax_q <= wd_w;
                    `VIDC_R_VMAX: vmax_q <= wd_w;
                    `VIDC_R_MARGIN: margin_q <= wd_w;
                    `VIDC_R_MULTI: multi_q <= wd_w;
                    default: ;
                endcase
            end
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            target_q <= `VIDC_VBOOT_RST;
            slow_q <= 1'b0;
            ps_q <= 2'h0;
        end else begin
            if (c_tgt_w) begin
                target_q <= f_pay_w; // [R14]
                slow_q <= c_slow_w; // [R17]
            end else if (ctrl_boot_w) begin
                target_q <= vboot_q; // [R15]
            end
            if (c_ps_w) begin
                ps_q <= f_pay_w[1:0]; // [R3]
            end
        end
    end

    // Bus errors: set wins over the clear done by reading
    wire [7:0] err_w = {5'h00, short_w, c_wr_w & mg_bad_w, c_bad_w};
    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            stat2_q <= 8'h00;
            stat2p_q <= 8'h00;
        end else begin
            stat2_q <= (rd_st2_w ? 8'h00 : stat2_q) | err_w; // [R12]
            if (rd_st2_w) begin
                stat2p_q <= stat2_q; // [R13]
            end
        end
    end

    // Effective target, clamped to the code range
    wire [7:0] eff_w = sum_w[8] ? (margin_q[7] ? 8'h00 : 8'hFF)
                                : sum_w[7:0]; // [R20]
    wire [4:0] per_w = slow_q ? 5'(`VIDC_SLOW_CYC - 1) : 5'(`VIDC_FAST_CYC - 1);
    wire step_w = (ramp_q != VIDC_IDLE) & (tick_q == per_w); // [R1] [R2]

    always_comb begin
        ramp_d = VIDC_IDLE;
        case (ramp_q)
            VIDC_IDLE, VIDC_UP, VIDC_DOWN: begin
                if (eff_w > sp_q) begin
                    ramp_d = VIDC_UP;
                end else if (eff_w < sp_q) begin
                    ramp_d = VIDC_DOWN;
                end
            end
            default: ramp_d = VIDC_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            ramp_q <= VIDC_IDLE;
            tick_q <= 5'h00;
            sp_q <= `VIDC_VBOOT_RST;
        end else begin
            ramp_q <= ramp_d;
            if (c_tgt_w || ramp_q == VIDC_IDLE || step_w) begin
                tick_q <= 5'h00;
            end else begin
                tick_q <= tick_q + 5'h01;
            end
            if (step_w && ramp_q == VIDC_UP && eff_w > sp_q) begin
                sp_q <= sp_q + 8'h01; // [R1] [R2]
            end else if (step_w && ramp_q == VIDC_DOWN && eff_w < sp_q) begin
                sp_q <= sp_q - 8'h01;
            end
        end
    end

    logic [7:0] rd_mux;
    wire [7:0] rd_sel_w = c_rd_w ? f_pay_w : reg_addr_in;
    wire [7:0] stat1_w = {6'h00, sp_q == 8'h00, ramp_q != VIDC_IDLE};
    always_comb begin
        case (rd_sel_w) // [R6] [R16] [R17] [R18]
            `VIDC_R_MAKER: rd_mux = MAKER_ID;
            `VIDC_R_PRODUCT: rd_mux = PRODUCT_ID;
            `VIDC_R_REV: rd_mux = REVISION_ID;
            `VIDC_R_PROTO: rd_mux = `VIDC_PROTO_RST;
            `VIDC_R_CAPAB: rd_mux = `VIDC_CAPAB_RST;
            `VIDC_R_STAT1: rd_mux = stat1_w;
            `VIDC_R_STAT2: rd_mux = stat2_q;
            `VIDC_R_TZONE: rd_mux = temp_zone_in;
            `VIDC_R_CUR0: rd_mux = current_first_in;
            `VIDC_R_CUR1: rd_mux = current_second_in;
            `VIDC_R_STAT2P: rd_mux = stat2p_q;
            `VIDC_R_ICCMAX: rd_mux = icc_q;
            `VIDC_R_TMAX: rd_mux = tmax_q;
            `VIDC_R_SRFAST: rd_mux = 8'(`VIDC_FAST_RAMP_RATE_MV_US);
            `VIDC_R_SRSLOW: rd_mux = 8'(`VIDC_SLOW_RAMP_RATE_MV_US);
            `VIDC_R_VBOOT: rd_mux = vboot_q;
            `VIDC_R_VMAX: rd_mux = vmax_q;
            `VIDC_R_TARGET: rd_mux = target_q;
            `VIDC_R_PSTATE: rd_mux = {6'h00, ps_q};
            `VIDC_R_MARGIN: rd_mux = margin_q;
            `VIDC_R_MULTI: rd_mux = multi_q;
            `VIDC_R_PTR: rd_mux = ptr_q;
            default: rd_mux = 8'h00;
        endcase
    end

    wire ack_w = c_tgt_w | c_ps_w | c_ptr_w | c_rd_w | (c_wr_w & ~mg_bad_w); // [R22]
    // Code zero is off, else 245 mV plus 5 mV per code
    wire [10:0] mv_w = (sp_q == 8'h00) ? 11'd0
                     : 11'(`VIDC_MV_BASE + 11'(sp_q) * 11'd5); // [R10] [R11]

    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            reg_rdata_out <= 8'h00;
            reply_strobe_out <= 1'b0;
            reply_ack_out <= 1'b0;
            reply_data_out <= 8'h00;
            setpoint_code_out <= 8'h00;
            setpoint_mv_out <= 11'd0;
            power_state_out <= 2'h0;
        end else begin
            reg_rdata_out <= (reg_rd_in && !c_rd_w) ? rd_mux : 8'h00;
            reply_strobe_out <= go_w;
            reply_ack_out <= ack_w;
            reply_data_out <= c_rd_w ? rd_mux : 8'h00; // [R6]
            setpoint_code_out <= sp_q;
            setpoint_mv_out <= mv_w;
            power_state_out <= ps_q; // [R3]
        end
    end

    fast_gap_a: assert property (@(posedge ref_clk_in) disable iff (reset_in) // [R1]
        (step_w && !slow_q && !c_tgt_w) |=> !step_w [*4])
        else $error("fast ramp stepped too early");
    slow_gap_a: assert property (@(posedge ref_clk_in) disable iff (reset_in) // [R2]
        (step_w && slow_q && !c_tgt_w) |=> !step_w [*8])
        else $error("slow ramp stepped too early");
    ramp_cause_a: assert property (@(posedge ref_clk_in) disable iff (reset_in) // [R1]
        (sp_q != $past(sp_q)) |-> $past(step_w))
        else $error("set point moved without a step");
    pstate_out_a: assert property (@(posedge ref_clk_in) disable iff (reset_in) // [R3]
        c_ps_w |-> ##2 power_state_out == $past(f_pay_w[1:0], 2))
        else $error("power state not reported");
    ptr_store_a: assert property (@(posedge ref_clk_in) disable iff (reset_in) // [R4]
        c_ptr_w |=> ptr_q == $past(f_pay_w))
        else $error("pointer not stored");
    ptr_write_a: assert property (@(posedge ref_clk_in) disable iff (reset_in) // [R5]
        (c_wr_w && ptr_q == `VIDC_R_TMAX) |=> tmax_q == $past(f_pay_w))
        else $error("pointed write lost");
    read_reply_a: assert property (@(posedge ref_clk_in) disable iff (reset_in) // [R6]
        (c_rd_w && f_pay_w == `VIDC_R_TARGET) |=> reply_strobe_out && reply_ack_out
            && reply_data_out == $past(target_q))
        else $error("read reply wrong");
    bad_cmd_a: assert property (@(posedge ref_clk_in) disable iff (reset_in) // [R23]
        c_bad_w |=> !reply_ack_out && $stable(target_q) && stat2_q[0])
        else $error("unsupported command had effect");
    margin_ref_a: assert property (@(posedge ref_clk_in) disable iff (reset_in) // [R9]
        (c_wr_w && mg_bad_w) |=> !reply_ack_out && $stable(margin_q))
        else $error("out of range margin accepted");
    mv_map_a: assert property (@(posedge ref_clk_in) disable iff (reset_in) // [R11]
        (sp_q == 8'h02) |=> setpoint_mv_out == 11'd255)
        else $error("code 0x02 not 255 mV");
    target_upd_a: assert property (@(posedge ref_clk_in) disable iff (reset_in) // [R14]
        c_tgt_w |=> target_q == $past(f_pay_w))
        else $error("target not updated");
    stat2_copy_a: assert property (@(posedge ref_clk_in) disable iff (reset_in) // [R13]
        rd_st2_w |=> stat2p_q == $past(stat2_q))
        else $error("previous bus error status lost");
    short_flag_a: assert property (@(posedge ref_clk_in) disable iff (reset_in) // [R12]
        short_w |=> stat2_q[2])
        else $error("short frame not recorded");
    boot_load_a: assert property (@(posedge ref_clk_in) disable iff (reset_in) // [R15]
        (ctrl_boot_w && !c_tgt_w) |=> target_q == $past(vboot_q))
        else $error("boot code not loaded");
endmodule

/* File: hw/vidc_defines.svh */
/*
 Offsets, field layout, reset values and timing counts of the target-code interpreter.
 Included by the design file only.
*/
`ifndef VIDC_DEFINES_SVH
`define VIDC_DEFINES_SVH
`define VIDC_FRAME_BITS 4'hF
`define VIDC_BCAST_A 4'hE
`define VIDC_BCAST_B 4'hF
`define VIDC_R_MAKER 8'h00
`define VIDC_R_PRODUCT 8'h01
`define VIDC_R_REV 8'h02
`define VIDC_R_PROTO 8'h05
`define VIDC_R_CAPAB 8'h06
`define VIDC_R_STAT1 8'h10
`define VIDC_R_STAT2 8'h11
`define VIDC_R_TZONE 8'h12
`define VIDC_R_CUR0 8'h15
`define VIDC_R_CUR1 8'h16
`define VIDC_R_STAT2P 8'h1C
`define VIDC_R_ICCMAX 8'h21
`define VIDC_R_TMAX 8'h22
`define VIDC_R_SRFAST 8'h24
`define VIDC_R_SRSLOW 8'h25
`define VIDC_R_VBOOT 8'h26
`define VIDC_R_VMAX 8'h30
`define VIDC_R_TARGET 8'h31
`define VIDC_R_PSTATE 8'h32
`define VIDC_R_MARGIN 8'h33
`define VIDC_R_MULTI 8'h34
`define VIDC_R_PTR 8'h35
`define VIDC_R_CTRL 8'h40
`define VIDC_VBOOT_RST 8'h97
`define VIDC_CAPAB_RST 8'h81
`define VIDC_PROTO_RST 8'h01
`define VIDC_FAST_RAMP_RATE_MV_US 20
`define VIDC_SLOW_RAMP_RATE_MV_US 5
`define VIDC_STEP_MV 5
`define VIDC_CLK_MHZ 20
`define VIDC_FAST_CYC ((`VIDC_STEP_MV * `VIDC_CLK_MHZ) / `VIDC_FAST_RAMP_RATE_MV_US)
`define VIDC_SLOW_CYC ((`VIDC_STEP_MV * `VIDC_CLK_MHZ) / `VIDC_SLOW_RAMP_RATE_MV_US)
`define VIDC_MV_BASE 11'd245
`define VIDC_CODE_MAX 9'h0FF
`endif

/* File: hw/vidc_pkg.sv */
/*
 Types of the target-code interpreter: command codes and ramp states.
 Assumes nothing of its surroundings.
*/
package vidc_pkg;
    typedef enum logic [2:0] {
        VIDC_CMD_TRIM = 3'h0, VIDC_CMD_FAST = 3'h1, VIDC_CMD_SLOW = 3'h2,
        VIDC_CMD_DECAY = 3'h3, VIDC_CMD_PS = 3'h4, VIDC_CMD_PTR = 3'h5,
        VIDC_CMD_WRITE = 3'h6, VIDC_CMD_READ = 3'h7
    } vidc_cmd_t;
    typedef enum logic [2:0] {
        VIDC_IDLE = 3'b001, VIDC_UP = 3'b010, VIDC_DOWN = 3'b100
    } vidc_ramp_t;
endpackage

/* File: testbench/vidc_master.sv */
/*
 Bus master model: sends frames on the link pins.
 Assumes the interpreter samples data on link clock rising edges.
*/
`timescale 1ns/1ps
module vidc_master
    import vidc_pkg::*;
(
    output logic link_clk_out, // Link clock, still between frames
    output logic link_frame_out, // Frame active
    output logic link_data_out // Serial data
);
    initial begin
        link_clk_out = 1'b0;
        link_frame_out = 1'b0;
        link_data_out = 1'b1;
    end
    // Address, code, payload, MSB first; fewer than 15 bits cuts the frame short
    task automatic send(input logic [3:0] a, input vidc_cmd_t c, input logic [7:0] p,
                        input int nbits = 15);
        logic [14:0] w;
        w = {a, c, p};
        if (c == VIDC_CMD_TRIM)
            return;
        #37;
        link_frame_out = 1'b1;
        for (int i = 14; i > 14 - nbits; i--) begin
            link_data_out = w[i];
            #200 link_clk_out = 1'b1;
            #200 link_clk_out = 1'b0;
        end
        // Released line shows the inverse
        link_data_out = ~w[0];
        #100 link_frame_out = 1'b0;
        #400;
    endtask
endmodule

/* File: testbench/vidc_core_tb.sv */
/*
 Self-checking bench of the interpreter: link frames and register port.
 Assumes strap address 3, then 9 after the second reset, and a 20 MHz reference clock.
*/
`timescale 1ns/1ps
module vidc_core_tb
    import vidc_pkg::*;
;
    localparam int FAST_CYC = 5 * 20 / 20;
    localparam int SLOW_CYC = 5 * 20 / 5;
    logic ref_clk_in = 1'b0, reset_in = 1'b1;
    logic [7:0] temp = 8'h00, cur0 = 8'h00, cur1 = 8'h00, r_addr = 8'h00, r_wdata = 8'h00;
    logic r_wr = 1'b0, r_rd = 1'b0, rd_q = 1'b0;
    logic [3:0] strap = 4'h3;
    logic [7:0] reg_rdata, rep_data, sp_code, rnd;
    logic rep_stb, rep_ack, lclk, lframe, ldata;
    logic [10:0] sp_mv;
    logic [1:0] pstate;
    logic [7:0] reg_q[$];
    logic [8:0] rep_q[$];
    int n_fail = 0, tests_run = 0;
    logic [7:0] init_a[9] = '{8'h00, 8'h01, 8'h02, 8'h05, 8'h06, 8'h24, 8'h25, 8'h26, 8'h31};
    logic [7:0] init_v[9] = '{8'h5A, 8'h3C, 8'h01, 8'h01, 8'h81, 8'h14, 8'h05, 8'h97, 8'h97};

    vidc_core i_dut (.ref_clk_in(ref_clk_in), .reset_in(reset_in), .addr_strap_in(strap),
        .link_clk_in(lclk), .link_frame_in(lframe), .link_data_in(ldata),
        .temp_zone_in(temp), .current_first_in(cur0), .current_second_in(cur1),
        .reg_addr_in(r_addr), .reg_wdata_in(r_wdata), .reg_wr_in(r_wr), .reg_rd_in(r_rd),
        .reg_rdata_out(reg_rdata), .reply_strobe_out(rep_stb), .reply_ack_out(rep_ack),
        .reply_data_out(rep_data), .setpoint_code_out(sp_code), .setpoint_mv_out(sp_mv),
        .power_state_out(pstate));
    vidc_master i_master (.link_clk_out(lclk), .link_frame_out(lframe), .link_data_out(ldata));

    initial begin
        forever #25 ref_clk_in = ~ref_clk_in;
    end

    task automatic fail(input string m);
        n_fail++;
        $display("CHECK FAILED at %0t: %s", $time, m);
    endtask
    task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp)
            fail("register read data");
    endtask
    task automatic chk_reply(input logic [8:0] got, input logic [8:0] exp);
        tests_run++;
        if (got !== exp)
            fail("reply ack or data");
    endtask
    task automatic chk_val(input logic [10:0] got, input logic [10:0] exp);
        tests_run++;
        if (got !== exp)
            fail("output value");
    endtask
    task automatic test_done();
        $display("checks %0d, mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // Monitor: results taken off the queues in arrival order
    always @(posedge ref_clk_in) rd_q <= r_rd;
    always @(negedge ref_clk_in) begin
        if (rd_q) begin
            if (reg_q.size() == 0)
                fail("unexpected read");
            else
                chk_reg(reg_rdata, reg_q.pop_front());
        end
        if (rep_stb === 1'b1) begin
            if (rep_q.size() == 0)
                fail("unexpected reply");
            else
                chk_reply({rep_ack, rep_data}, rep_q.pop_front());
        end
    end

    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk_in);
        r_addr <= a;
        r_wdata <= d;
        r_wr <= 1'b1;
        @(posedge ref_clk_in);
        r_wr <= 1'b0;
    endtask
    task automatic reg_rd(input logic [7:0] a, input logic [7:0] exp);
        reg_q.push_back(exp);
        @(posedge ref_clk_in);
        r_addr <= a;
        r_rd <= 1'b1;
        @(posedge ref_clk_in);
        r_rd <= 1'b0;
        @(posedge ref_clk_in);
    endtask
    task automatic cmd(input logic [3:0] a, input vidc_cmd_t c, input logic [7:0] p,
                       input logic ack, input logic [7:0] d);
        rep_q.push_back({ack, d});
        i_master.send(a, c, p);
        repeat (10) @(posedge ref_clk_in);
    endtask
    // Cycles between two set-point steps
    task automatic gap(input int exp);
        logic [7:0] o;
        int n;
        @(negedge ref_clk_in);
        for (int k = 0; k < 2; k++) begin
            o = sp_code;
            n = 0;
            while (sp_code === o && n < 100) begin
                @(negedge ref_clk_in);
                n++;
            end
        end
        chk_val(11'(n), 11'(exp));
    endtask
    task automatic settle(input logic [7:0] c, input logic [10:0] mv);
        int n;
        n = 0;
        while (sp_code !== c && n < 4000) begin
            @(negedge ref_clk_in);
            n++;
        end
        repeat (2) @(negedge ref_clk_in);
        chk_val({3'h0, sp_code}, {3'h0, c});
        chk_val(sp_mv, mv);
    endtask

    initial begin
        #2000000;
        fail("timeout");
        test_done();
    end

    initial begin
        void'($urandom(32'h1F6D));
        repeat (16) @(posedge ref_clk_in);
        reset_in <= 1'b0;
        temp <= 8'($urandom);
        cur0 <= 8'($urandom);
        cur1 <= 8'($urandom);
        rnd = 8'($urandom);
        repeat (3) @(negedge ref_clk_in);
        chk_val(sp_mv, 11'd1000);
        for (int i = 0; i < 9; i++)
            reg_rd(init_a[i], init_v[i]);
        reg_rd(8'h12, temp);
        reg_rd(8'h15, cur0);
        reg_rd(8'h16, cur1);
        cmd(4'h3, VIDC_CMD_FAST, 8'hA7, 1'b1, 8'h00);
        gap(FAST_CYC);
        settle(8'hA7, 11'd1080);
        reg_rd(8'h31, 8'hA7);
        cmd(4'h3, VIDC_CMD_SLOW, 8'h01, 1'b1, 8'h00);
        gap(SLOW_CYC);
        settle(8'h01, 11'd250);
        cmd(4'h3, VIDC_CMD_FAST, 8'h00, 1'b1, 8'h00);
        settle(8'h00, 11'd0);
        cmd(4'hE, VIDC_CMD_PS, 8'h02, 1'b1, 8'h00);
        chk_val({9'h0, pstate}, 11'h002);
        reg_rd(8'h32, 8'h02);
        i_master.send(4'h5, VIDC_CMD_FAST, 8'h10);
        repeat (10) @(posedge ref_clk_in);
        cmd(4'h3, VIDC_CMD_DECAY, 8'h40, 1'b0, 8'h00);
        reg_rd(8'h31, 8'h00);
        cmd(4'h3, VIDC_CMD_PTR, 8'h22, 1'b1, 8'h00);
        cmd(4'h3, VIDC_CMD_WRITE, rnd, 1'b1, 8'h00);
        cmd(4'h3, VIDC_CMD_READ, 8'h22, 1'b1, rnd);
        reg_rd(8'h35, 8'h22);
        cmd(4'h3, VIDC_CMD_PTR, 8'h33, 1'b1, 8'h00);
        cmd(4'h3, VIDC_CMD_WRITE, 8'h80, 1'b0, 8'h00);
        reg_rd(8'h11, 8'h03);
        cmd(4'h3, VIDC_CMD_READ, 8'h11, 1'b1, 8'h03);
        reg_rd(8'h1C, 8'h03);
        reg_rd(8'h11, 8'h00);
        cmd(4'h3, VIDC_CMD_WRITE, 8'h7F, 1'b1, 8'h00);
        reg_rd(8'h33, 8'h7F);
        reg_wr(8'h26, 8'hA0);
        reg_wr(8'h40, 8'h01);
        reg_rd(8'h31, 8'hA0);
        reg_wr(8'h24, 8'h00);
        reg_rd(8'h24, 8'h14);
        reg_rd(8'h7F, 8'h00);
        reg_wr(8'h34, rnd);
        reg_rd(8'h34, rnd);
        reg_wr(8'h30, 8'hC8);
        reg_rd(8'h30, 8'hC8);
        i_master.send(4'h3, VIDC_CMD_FAST, 8'h55, 9);
        repeat (10) @(posedge ref_clk_in);
        reg_rd(8'h11, 8'h04);
        reg_rd(8'h31, 8'hA0);
        // Second reset, new strap address
        @(posedge ref_clk_in);
        reset_in <= 1'b1;
        strap <= 4'h9;
        repeat (4) @(posedge ref_clk_in);
        reset_in <= 1'b0;
        i_master.send(4'h3, VIDC_CMD_FAST, 8'h20);
        repeat (10) @(posedge ref_clk_in);
        cmd(4'h9, VIDC_CMD_READ, 8'h31, 1'b1, 8'h97);
        repeat (5) @(posedge ref_clk_in);
        if (reg_q.size() != 0 || rep_q.size() != 0)
            fail("missing result");
        test_done();
    end
endmodule
